/* File: spc_pkg.sv */
// Shared constants and types for the sector protection control block.
// Assumes a 200 MHz core clock; all timing counts derive from it here.
package spc_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS            = 5;    // Core clock period
   localparam int PROTECT_ASSERT_DELAY_NS  = 200;  // Longest pin-to-protect time
   localparam int PROTECT_RELEASE_DELAY_NS = 200;  // Longest pin-to-release time
   localparam int WP_FILTER_NS             = 100;  // Least stable time before a pin change counts
   // Least time rounds up to whole cycles
   localparam int WP_FILTER_CYC = (WP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest times round down
   localparam int PROTECT_ASSERT_CYC  = PROTECT_ASSERT_DELAY_NS / CLK_PERIOD_NS;
   localparam int PROTECT_RELEASE_CYC = PROTECT_RELEASE_DELAY_NS / CLK_PERIOD_NS;
   localparam int FILT_CNT_W = 5;                  // Holds WP_FILTER_CYC
   localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(WP_FILTER_CYC - 1);
   localparam logic [FILT_CNT_W-1:0] FILT_ZERO = 5'h00;
   localparam logic [FILT_CNT_W-1:0] FILT_ONE  = 5'h01;

   // ***************************************************************
   // Command frames
   // ***************************************************************
   localparam int BYTE_W  = 8;
   localparam int FRAME_W = 32;                    // Four command bytes
   localparam logic [BYTE_W-1:0] CMD_BYTE0        = 8'h3D;
   localparam logic [BYTE_W-1:0] CMD_BYTE1        = 8'h2A;
   localparam logic [BYTE_W-1:0] CMD_BYTE2        = 8'h7F;
   localparam logic [BYTE_W-1:0] CMD_ENABLE_TAIL  = 8'hA9;
   localparam logic [BYTE_W-1:0] CMD_DISABLE_TAIL = 8'h9A;
   localparam logic [FRAME_W-1:0] CMD_ENABLE  = {CMD_BYTE0, CMD_BYTE1, CMD_BYTE2, CMD_ENABLE_TAIL};
   localparam logic [FRAME_W-1:0] CMD_DISABLE = {CMD_BYTE0, CMD_BYTE1, CMD_BYTE2, CMD_DISABLE_TAIL};
   localparam int BIT_CNT_W = 6;
   localparam logic [BIT_CNT_W-1:0] BITS_FRAME = 6'h20;  // Exactly 32 bits
   localparam logic [BIT_CNT_W-1:0] BITS_ZERO  = 6'h00;
   localparam logic [BIT_CNT_W-1:0] BITS_ONE   = 6'h01;

   // ***************************************************************
   // Sector protection register layout
   // ***************************************************************
   localparam int SECTORS    = 16;
   localparam int SECTOR_W   = 4;
   localparam logic [BYTE_W-1:0] PROT_MARK    = 8'hFF;  // Sectors 1..15 protected
   localparam logic [1:0]        SUB_MARK     = 2'h3;   // Sector 0 halves protected
   localparam logic [SECTOR_W-1:0] SECTOR_ZERO = 4'h0;
   localparam int SUB0A_HI = 7;
   localparam int SUB0A_LO = 6;
   localparam int SUB0B_HI = 5;
   localparam int SUB0B_LO = 4;

   // ***************************************************************
   // Pin synchroniser lanes and idle levels
   // ***************************************************************
   localparam int PIN_N    = 4;
   localparam int PIN_SCK  = 0;
   localparam int PIN_CSN  = 1;
   localparam int PIN_SI   = 2;
   localparam int PIN_WPN  = 3;
   localparam logic [PIN_N-1:0] PIN_IDLE = 4'hA;   // wp_n high, cs_n high

   // Frame receiver states
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,   // Chip not selected
      RX_SHIFT = 2'b01,   // Collecting bits
      RX_OVER  = 2'b10    // More than one frame of bits, never a command here
   } spc_rx_e;

endpackage : spc_pkg

/* File: spc_filt_if.sv */
// Carrier between the protection core and its write-protect filter.
// Assumes the level is already synchronised to the core clock.
`timescale 1ns/100ps
interface spc_filt_if;
   import spc_pkg::*;
   logic level_in;    // Synchronised write-protect level, active low
   logic level_out;   // Filtered write-protect level, active low
   modport filt (input level_in, output level_out);
   modport user (output level_in, input level_out);
endinterface : spc_filt_if

/* File: spc_deglitch.sv */
// Noise filter for the write-protect level.
// Assumes its input is synchronous to clock; output changes only after
// the input has held a new level for WP_FILTER_CYC cycles.
`timescale 1ns/100ps
module spc_deglitch
   import spc_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  nrst,
   input  wire logic  clk_en,
   spc_filt_if.filt   fif
);

   // ***************************************************************
   // Filter state
   // ***************************************************************
   logic                  out_reg;   // Filtered level
   logic                  out_next;
   logic [FILT_CNT_W-1:0] cnt_reg;   // Cycles the input has differed
   logic [FILT_CNT_W-1:0] cnt_next;

   // Next state: a differing level must persist before it is taken
   always_comb begin
      out_next = out_reg;
      cnt_next = FILT_ZERO;
      if (fif.level_in != out_reg) begin
         if (cnt_reg == FILT_LAST) begin
            out_next = fif.level_in;
         end else begin
            cnt_next = cnt_reg + FILT_ONE; // Any return to old level restarts
         end
      end
   end

   // Registers; idle level is deasserted so power-up never protects
   always_ff @(posedge clock) begin
      if (!nrst) begin
         out_reg <= 1'b1;
         cnt_reg <= FILT_ZERO;
      end else if (clk_en) begin
         out_reg <= out_next;
         cnt_reg <= cnt_next;
      end
   end

   assign fif.level_out = out_reg;

   // ***************************************************************
   // Checks
   // ***************************************************************
   filt_take_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && fif.level_in != out_reg && cnt_reg == FILT_LAST)
      |=> (out_reg == $past(fif.level_in)))
      else $error("Filter did not take a held level");

   filt_glitch_a: assert property (@(posedge clock) disable iff (!nrst)
      $changed(out_reg) |-> ($past(cnt_reg) == FILT_LAST))
      else $error("Filter output moved before the hold time");

endmodule : spc_deglitch

/* File: spc_sector_protect.sv */
// Sector protection control: decodes the enable and disable protection
// frames from the serial bus, filters the write-protect pin and judges
// program and erase requests against the protection register contents.
// Assumes bus pins and the write-protect pin are asynchronous to clock,
// the serial clock is well below a quarter of clock, and the board holds
// an undriven write-protect pin high.
`timescale 1ns/100ps
module spc_sector_protect
   import spc_pkg::*;
(
   input  wire logic                clock,         // 200 MHz core clock
   input  wire logic                nrst,          // Synchronous reset, active low
   input  wire logic                clk_en,        // Freezes all state when low
   input  wire logic                sck,           // Serial clock pin
   input  wire logic                cs_n,          // Chip select pin, active low
   input  wire logic                si,            // Serial data in pin
   input  wire logic                wp_n,          // Write-protect pin, active low
   input  wire logic [SECTORS*BYTE_W-1:0] prot_bytes, // Protection register, byte 0 low
   input  wire logic                op_req,        // Program or erase request pulse
   input  wire logic [SECTOR_W-1:0] op_sector,     // Target sector
   input  wire logic                op_sub_b,      // Sector 0: second half targeted
   input  wire logic                op_spr,        // Target is the protection register
   output logic                     op_done,       // Verdict valid pulse
   output logic                     op_allowed,    // Verdict: operation may proceed
   output logic                     prot_status    // Status bit: protection active
);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [PIN_N-1:0] pin_s1_reg;   // First stage, read only by second stage
   logic [PIN_N-1:0] pin_s2_reg;   // Second stage, safe to use
   logic [PIN_N-1:0] pin_raw;
   logic             sck_d_reg;    // Delayed copies for edge finding
   logic             csn_d_reg;

   assign pin_raw = {wp_n, si, cs_n, sck};

   // Two flops per pin; data and clock share the delay so they stay aligned
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pin_s1_reg <= PIN_IDLE;
         pin_s2_reg <= PIN_IDLE;
         sck_d_reg  <= PIN_IDLE[PIN_SCK];
         csn_d_reg  <= PIN_IDLE[PIN_CSN];
      end else if (clk_en) begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         sck_d_reg  <= pin_s2_reg[PIN_SCK];
         csn_d_reg  <= pin_s2_reg[PIN_CSN];
      end
   end

   logic sck_rise;   // Serial clock rising edge, sample point in modes 0 and 3
   logic cs_rise;    // Chip select released
   logic cs_low;
   assign sck_rise = pin_s2_reg[PIN_SCK] && !sck_d_reg;
   assign cs_rise  = pin_s2_reg[PIN_CSN] && !csn_d_reg;
   assign cs_low   = !pin_s2_reg[PIN_CSN];

   // ***************************************************************
   // Write-protect filter
   // ***************************************************************
   spc_filt_if fif ();
   assign fif.level_in = pin_s2_reg[PIN_WPN];

   spc_deglitch u_filt (
      .clock  (clock),
      .nrst   (nrst),
      .clk_en (clk_en),
      .fif    (fif.filt)
   );

   logic wp_on;      // Filtered pin asserted
   // A floating pin is pulled high, so only a driven low protects
   assign wp_on = !fif.level_out;

   // ***************************************************************
   // Frame receiver
   // ***************************************************************
   spc_rx_e              rx_reg;      // Receiver state
   spc_rx_e              rx_next;
   logic [FRAME_W-1:0]   shift_reg;   // Last bits received, newest low
   logic [FRAME_W-1:0]   shift_next;
   logic [BIT_CNT_W-1:0] bits_reg;    // Bits in this frame
   logic [BIT_CNT_W-1:0] bits_next;
   logic                 soft_reg;    // Software protection flag
   logic                 soft_next;
   logic                 frame_ok;    // Exactly one frame received

   assign frame_ok = (rx_reg == RX_SHIFT) && (bits_reg == BITS_FRAME);

   // Next state: shift on serial edges, act only on chip-select release
   always_comb begin
      rx_next    = rx_reg;
      shift_next = shift_reg;
      bits_next  = bits_reg;
      soft_next  = soft_reg;
      unique case (rx_reg)
         RX_IDLE: begin
            if (cs_low) begin
               rx_next   = RX_SHIFT;
               bits_next = BITS_ZERO;
            end
         end
         RX_SHIFT: begin
            if (cs_rise || !cs_low) begin
               rx_next = RX_IDLE;
               if (frame_ok && shift_reg == CMD_ENABLE) begin
                  soft_next = 1'b1;
               end else if (frame_ok && shift_reg == CMD_DISABLE && !wp_on) begin
                  soft_next = 1'b0;
               end
            end else if (sck_rise) begin
               shift_next = {shift_reg[FRAME_W-2:0], pin_s2_reg[PIN_SI]};
               if (bits_reg == BITS_FRAME) begin
                  rx_next = RX_OVER;  // Longer frames belong to other commands
               end else begin
                  bits_next = bits_reg + BITS_ONE;
               end
            end
         end
         RX_OVER: begin
            if (!cs_low) begin
               rx_next = RX_IDLE;
            end
         end
         default: begin
            rx_next = RX_IDLE;
         end
      endcase
   end

   // Registers; reset stands for power-up and drops software protection
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rx_reg    <= RX_IDLE;
         shift_reg <= '0;
         bits_reg  <= BITS_ZERO;
         soft_reg  <= 1'b0;
      end else if (clk_en) begin
         rx_reg    <= rx_next;
         shift_reg <= shift_next;
         bits_reg  <= bits_next;
         soft_reg  <= soft_next;
      end
   end

   // ***************************************************************
   // Protection verdict
   // ***************************************************************
   logic                  prot_active;  // Effective protection
   logic [BYTE_W-1:0]     sel_byte;     // Protection byte of target sector
   logic                  marked;       // Target sector is marked
   logic                  deny;
   logic                  status_reg;
   logic                  status_next;
   logic                  done_reg;
   logic                  done_next;
   logic                  allow_reg;
   logic                  allow_next;

   // The pin can only add protection; it never clears the software flag
   assign prot_active = soft_reg || wp_on;
   assign sel_byte    = prot_bytes[op_sector*BYTE_W +: BYTE_W];

   // Decode the marking; values other than the documented ones protect nothing
   always_comb begin
      if (op_sector == SECTOR_ZERO) begin
         marked = op_sub_b ? (sel_byte[SUB0B_HI:SUB0B_LO] == SUB_MARK)
                           : (sel_byte[SUB0A_HI:SUB0A_LO] == SUB_MARK);
      end else begin
         marked = (sel_byte == PROT_MARK);
      end
      // Register is locked only by the pin; sectors by either method
      deny = op_spr ? wp_on : (prot_active && marked);
   end

   // Next verdict and status
   always_comb begin
      status_next = prot_active;
      done_next   = op_req;
      allow_next  = allow_reg;
      if (op_req) begin
         allow_next = !deny;
      end
   end

   // Verdict and status flops; outputs come straight from them
   always_ff @(posedge clock) begin
      if (!nrst) begin
         status_reg <= 1'b0;
         done_reg   <= 1'b0;
         allow_reg  <= 1'b0;
      end else if (clk_en) begin
         status_reg <= status_next;
         done_reg   <= done_next;
         allow_reg  <= allow_next;
      end
   end

   assign prot_status = status_reg;
   assign op_done     = done_reg;
   assign op_allowed  = allow_reg;

   // ***************************************************************
   // Checks
   // ***************************************************************
   sequence frame_end_s(logic [FRAME_W-1:0] cmd);
      clk_en && rx_reg == RX_SHIFT && cs_rise && frame_ok && shift_reg == cmd;
   endsequence

   enable_cmd_a: assert property (@(posedge clock) disable iff (!nrst)
      frame_end_s(CMD_ENABLE) |=> soft_reg ##1 (status_reg || !$past(clk_en)))
      else $error("Enable frame did not set protection");

   disable_cmd_a: assert property (@(posedge clock) disable iff (!nrst)
      (frame_end_s(CMD_DISABLE) and !wp_on) |=> !soft_reg)
      else $error("Disable frame did not clear protection");

   short_frame_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && rx_reg == RX_SHIFT && cs_rise && bits_reg != BITS_FRAME)
      |=> $stable(soft_reg))
      else $error("Incomplete frame changed protection");

   power_up_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> !soft_reg && !status_reg)
      else $error("Protection active after reset");

   disable_ignored_a: assert property (@(posedge clock) disable iff (!nrst)
      (frame_end_s(CMD_DISABLE) and wp_on) |=> soft_reg == $past(soft_reg))
      else $error("Disable frame acted while pin asserted");

   pin_forces_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && wp_on) |=> status_reg)
      else $error("Asserted pin did not protect");

   pin_release_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && $fell(wp_on) && !soft_reg) ##1 clk_en |-> !status_reg)
      else $error("Released pin left protection on");

   // A disable frame landing on the release cycle may legally clear the flag
   soft_holds_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && $fell(wp_on) && soft_reg && !cs_rise) |=> soft_reg && status_reg)
      else $error("Pin release removed software protection");

   spr_lock_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && op_req && op_spr && wp_on) |=> op_done && !op_allowed)
      else $error("Protection register writable under pin");

   marked_block_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && op_req && !op_spr && op_sector != SECTOR_ZERO && sel_byte == PROT_MARK
       && prot_active) |=> !op_allowed)
      else $error("Marked sector was writable");

   unmarked_open_a: assert property (@(posedge clock) disable iff (!nrst)
      (clk_en && op_req && !op_spr && !marked) |=> op_allowed)
      else $error("Unmarked sector was blocked");

endmodule : spc_sector_protect

/* File: spc_host_model.sv */
// Host model: frames on the serial bus and the write-protect pin.
// Assumes the block samples these pins with its own faster clock.
`timescale 1ns/100ps
module spc_host_model
   import spc_pkg::*;
(
   input  wire logic clock,  // Core clock, paces pin changes
   output logic      sck,    // Serial clock, still outside frames
   output logic      cs_n,   // Chip select, active low
   output logic      si,     // Serial data, MSB first
   output logic      wp_n    // Write-protect pin, active low
);
   localparam int HALF_NS = 32;  // Half of the 64 ns serial period

   // ***************************************************************
   // Idle pin levels
   // ***************************************************************
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
      wp_n = 1'b1;  // Pull-up holds an undriven pin deasserted
   end

   // Frame of nbits, MSB first, applied at chip-select release
   task automatic send_frame(input logic [39:0] bits, input int nbits);
      @(posedge clock);
      cs_n <= 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         si <= bits[i];
         #(HALF_NS) sck <= 1'b1;
         #(HALF_NS) sck <= 1'b0;
      end
      #(HALF_NS) cs_n <= 1'b1;
      si <= ~si;  // Released line must not keep the last bit
   endtask : send_frame

   // Pin level, then hold for some cycles; short holds make glitches
   task automatic drive_wp(input logic level, input int cycles);
      @(posedge clock);
      wp_n <= level;
      repeat (cycles) @(posedge clock);
   endtask : drive_wp
endmodule : spc_host_model

/* File: tb.sv */
// Self-checking bench for the sector protection control block.
// Assumes spc_pkg and the host model are compiled first.
`timescale 1ns/100ps
module tb;
   import spc_pkg::*;
   logic                      clock, nrst, clk_en, sck, cs_n, si, wp_n;
   logic [SECTORS*BYTE_W-1:0] prot_bytes;     // Protection register image
   logic                      op_req, op_sub_b, op_spr;
   logic [SECTOR_W-1:0]       op_sector;
   logic                      op_done, op_allowed, prot_status;
   logic                      soft_exp, wpf_exp; // Expected flag, filtered pin
   int                        n_mismatch, cmp_count;
   int                        seed;

   spc_sector_protect dut (.clock(clock), .nrst(nrst), .clk_en(clk_en),
      .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .prot_bytes(prot_bytes),
      .op_req(op_req), .op_sector(op_sector), .op_sub_b(op_sub_b),
      .op_spr(op_spr), .op_done(op_done), .op_allowed(op_allowed),
      .prot_status(prot_status));
   spc_host_model host (.clock(clock), .sck(sck), .cs_n(cs_n), .si(si),
      .wp_n(wp_n));

   // ***************************************************************
   // Clock and watchdog
   // ***************************************************************
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Whole run needs about 25 us; a hang ends here
   initial begin
      #(300_000);
      n_mismatch++;
      print_verdict();
   end

   // ***************************************************************
   // Checking helpers
   // ***************************************************************
   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic ok, input string what);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : chk

   // Verdict from sector marks and the two protection sources
   function automatic logic exp_ok(input logic spr, input logic [3:0] sec,
      input logic sub, input logic [127:0] pb, input logic sw, input logic wpf);
      logic [7:0] b;
      logic       marked;
      b = pb[sec*8 +: 8];
      if (sec == SECTOR_ZERO) marked = sub ? (b[5:4] == 2'h3) : (b[7:6] == 2'h3);
      else marked = (b == 8'hFF);
      if (spr) return !wpf;
      return !((sw | wpf) && marked);
   endfunction : exp_ok

   // Fresh register image: mostly FF/00, some odd values as unmarked
   task automatic new_bytes();
      int r;
      for (int k = 0; k < SECTORS; k++) begin
         r = $random(seed);
         // Sector 0 byte fully random so both halves are exercised
         prot_bytes[k*8 +: 8] <= (r[1:0] == 2'h0 || k == 0) ? r[15:8]
                                                             : (r[2] ? 8'hFF : 8'h00);
      end
   endtask : new_bytes

   // Back-to-back random requests; each verdict lands one edge later
   task automatic run_ops(input int n);
      int         r;
      logic       want;
      logic [3:0] sec;
      @(posedge clock);
      new_bytes();
      @(posedge clock);
      for (int i = 0; i <= n; i++) begin
         r = $random(seed);
         sec = (r[9:8] == 2'h0) ? SECTOR_ZERO : r[3:0];  // Sector 0 often, for its halves
         op_req    <= (i < n);
         op_sector <= sec;
         op_sub_b  <= r[4];
         op_spr    <= (r[7:5] == 3'h0);
         if (i > 0) begin
            #1;
            chk(op_done === 1'b1 && op_allowed === want, "verdict");
            chk(prot_status === (soft_exp | wpf_exp), "status");
         end
         // Keep the last real request's verdict; it must stand after the pulse
         if (i < n) begin
            want = exp_ok(r[7:5] == 3'h0, sec, r[4], prot_bytes, soft_exp, wpf_exp);
         end
         @(posedge clock);
      end
      #1;
      chk(op_done === 1'b0 && op_allowed === want, "done pulse or verdict hold");
   endtask : run_ops

   // Send a frame, then status must settle within ten cycles
   task automatic frame(input logic [39:0] bits, input int nbits);
      host.send_frame(bits, nbits);
      repeat (10) @(posedge clock);
      #1;
      chk(prot_status === (soft_exp | wpf_exp), "status after frame");
   endtask : frame

   // Status must hold its level for n cycles
   task automatic hold(input int n);
      repeat (n) begin
         @(posedge clock);
         #1;
         chk(prot_status === (soft_exp | wpf_exp), "status moved");
      end
   endtask : hold

   // Move the pin and see status follow within the longest delay
   task automatic set_wp(input logic level);
      int c;
      c = 0;
      host.drive_wp(level, 0);
      wpf_exp = !level;
      while (prot_status !== (soft_exp | wpf_exp)
             && c < (level ? PROTECT_RELEASE_CYC : PROTECT_ASSERT_CYC)) begin
         @(posedge clock);
         #1;
         c++;
      end
      chk(prot_status === (soft_exp | wpf_exp), "status after pin");
   endtask : set_wp

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      seed = 32'hCFC8B7F0;
      {nrst, op_req, op_sub_b, op_spr, op_sector} = '0;
      {clk_en, soft_exp, wpf_exp, prot_bytes} = {1'b1, 130'h0};
      n_mismatch = 0;
      cmp_count = 0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk(prot_status === 1'b0, "status after reset");
      run_ops(20);
      frame({9'h0, CMD_ENABLE[31:1]}, 31);
      frame({7'h0, CMD_ENABLE, 1'b1}, 33);
      frame({8'h0, CMD_BYTE0, CMD_BYTE1, CMD_BYTE2, 8'hCF}, 32);
      soft_exp = 1'b1;
      frame({8'h0, CMD_ENABLE}, 32);
      run_ops(40);
      soft_exp = 1'b0;
      frame({8'h0, CMD_DISABLE}, 32);
      run_ops(20);
      // Clock enable low freezes the pin path; a long pin pulse is never seen
      @(posedge clock);
      clk_en <= 1'b0;
      host.drive_wp(1'b0, 0);
      hold(45);
      @(posedge clock);
      clk_en <= 1'b1;
      host.drive_wp(1'b1, 0);
      hold(45);
      // Short pin glitches either way change nothing
      host.drive_wp(1'b0, 12);
      host.drive_wp(1'b1, 0);
      hold(45);
      set_wp(1'b0);
      run_ops(30);
      frame({8'h0, CMD_DISABLE}, 32);
      host.drive_wp(1'b1, 12);
      host.drive_wp(1'b0, 0);
      hold(45);
      set_wp(1'b1);
      soft_exp = 1'b1;
      frame({8'h0, CMD_ENABLE}, 32);
      set_wp(1'b0);
      frame({8'h0, CMD_DISABLE}, 32);
      set_wp(1'b1);
      hold(45);
      run_ops(20);
      soft_exp = 1'b0;
      frame({8'h0, CMD_DISABLE}, 32);
      set_wp(1'b0);
      soft_exp = 1'b1;
      frame({8'h0, CMD_ENABLE}, 32);
      set_wp(1'b1);
      hold(45);
      // Reset in mid-run drops the software flag
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      soft_exp = 1'b0;
      hold(10);
      print_verdict();
   end
endmodule : tb
